/* File: pkg/ssld_pkg.sv */
// constants and types shared by both ends of the sanitize-status and lock-disable link
`default_nettype none
package ssld_pkg;
  // command decode
  localparam logic [7:0] CMD_SANITIZE = 8'hb4;
  localparam logic [7:0] CMD_LOCK_OFF = 8'hf6;
  localparam logic [15:0] FEAT_STATUS = 16'h0000;
  // sector count fields
  localparam int CNT_CLEAR_FAILED = 0;
  localparam int CNT_DONE_OK = 15;
  localparam int CNT_IN_PROGRESS = 14;
  localparam int CNT_FROZEN = 13;
  localparam logic [15:0] PROGRESS_NONE = 16'hffff;
  // error reason codes
  localparam logic [7:0] REASON_NONE = 8'h00;
  localparam logic [7:0] REASON_UNSANITIZED = 8'h01;
  localparam logic [7:0] REASON_BAD_FEATURE = 8'h02;
  localparam logic [7:0] REASON_FROZEN = 8'h03;
  // error and status register bits
  localparam int ERR_ABORT = 2;
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEK_DONE = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // data sector layout, in 16-bit words
  localparam int SECTOR_WORDS = 256;
  localparam logic [7:0] WORD_CONTROL = 8'h00;
  localparam logic [7:0] WORD_PW_FIRST = 8'h01;
  localparam logic [7:0] WORD_PW_LAST = 8'h10;
  localparam logic [7:0] WORD_LAST = 8'hff;
  localparam int PW_BITS = 256;
  localparam int ID_BIT = 0;
  // host register map, byte offsets
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_PW_BASE = 8'h08;
  localparam logic [7:0] REG_PW_END = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_RESULT = 8'h2c;
  localparam int PW_REGS = 8;
  localparam int HST_DONE = 1;
  typedef enum logic [2:0] {
    SANITIZE_IDLE_STATE,
    SANITIZE_FROZEN_STATE,
    SANITIZE_ACTIVE_STATE,
    SANITIZE_FAILED_STATE,
    SANITIZE_SUCCEEDED_STATE
  } ssld_sanitize_t;
endpackage
`default_nettype wire

/* File: pkg/ssld_link_if.sv */
// command block link between host controller and drive command logic
`timescale 1ns/10ps
`default_nettype none
interface ssld_link_if;
  logic cmdStrobe;
  logic [7:0] cmdCode;
  logic [15:0] feature;
  logic [15:0] countIn;
  logic wordValid;
  logic [15:0] wordData;
  logic busy;
  logic drq;
  logic done;
  logic [7:0] statusReg;
  logic [7:0] errorReg;
  logic [15:0] countOut;
  logic [7:0] sectorNum;
  logic [7:0] cylLow;
  modport host_end (
    output cmdStrobe, cmdCode, feature, countIn, wordValid, wordData,
    input busy, drq, done, statusReg, errorReg, countOut, sectorNum, cylLow
  );
  modport device_end (
    input cmdStrobe, cmdCode, feature, countIn, wordValid, wordData,
    output busy, drq, done, statusReg, errorReg, countOut, sectorNum, cylLow
  );
endinterface
`default_nettype wire

/* File: rtl/ssld_pw_check.sv */
// word-by-word password comparator over the received sector
`timescale 1ns/10ps
`default_nettype none
module ssld_pw_check
  import ssld_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // received words
  input wire logic start,
  input wire logic wordTake,
  input wire logic [7:0] wordIndex,
  input wire logic [15:0] wordData,
  input wire logic useMaster,
  // stored passwords
  input wire logic [PW_BITS-1:0] userPassword,
  input wire logic [PW_BITS-1:0] masterPassword,
  // result
  output logic matched
);
  logic mismatch_q;
  logic [3:0] slot;
  logic [15:0] expected;

  assign slot = 4'(wordIndex - WORD_PW_FIRST);
  // identifier zero selects the user password, one the master
  assign expected = useMaster ? masterPassword[slot*16 +: 16] : userPassword[slot*16 +: 16];
  assign matched = !mismatch_q;

  always_ff @(posedge clock) begin
    if (!resetn || start) begin
      mismatch_q <= 1'b0;
    end else if (wordTake && wordIndex >= WORD_PW_FIRST && wordIndex <= WORD_PW_LAST
                 && wordData != expected) begin
      mismatch_q <= 1'b1;
    end
  end
endmodule // ssld_pw_check
`default_nettype wire

/* File: rtl/ssld_device.sv */
// drive-side command logic: sanitize status query and lock disable
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - decode B4h with feature 0000h as status
// - status query accepted in every sanitize state
// - clear flag, failed, persist set: go idle
// - clear flag, failed, persist clear: abort query
// - count bit 15 succeeded flag, survives reset
// - count bit 14 set while operation active
// - count bit 13 set while frozen
// - progress high byte cylinder, low sector
// - progress all ones when not active
// - unsanitized sectors left: abort status query
// - error reason code in sector number
// - decode F6h as lock disable
// - take one sector, disable lock on match
// - master password never changed by disable
// - security off and user identifier: abort
// - identifier picks user or master password
// - host issues disable whenever the link is not busy, locked or not
// - frozen state left to idle on reset
module ssld_device
  import ssld_pkg::*;
(
  // clock and resets
  input wire logic clock,
  input wire logic resetn,
  input wire logic retainResetn,
  // link to host
  ssld_link_if.device_end link,
  // sanitize engine events
  input wire logic opStart,
  input wire logic opPersist,
  input wire logic opFailed,
  input wire logic opSucceeded,
  input wire logic opUnsanitized,
  input wire logic freezeLock,
  input wire logic [15:0] progress,
  // security store
  input wire logic [PW_BITS-1:0] userPassword,
  input wire logic [PW_BITS-1:0] masterPassword,
  input wire logic setUserPassword,
  // state shown to the drive
  output ssld_sanitize_t sanitizeState,
  output logic securityEnabled,
  output logic lockDisabled
);
  typedef enum logic [1:0] {DEV_IDLE, DEV_RECEIVE, DEV_CHECK} ssld_dev_t;

  ssld_dev_t dev_q;
  ssld_sanitize_t san_q;
  logic persist_q;
  logic unsanitized_q;
  logic doneOk_q;
  logic secOn_q;
  logic idMaster_q;
  logic [7:0] wordCnt_q;
  logic busy_q, drq_q, done_q, lockOff_q;
  logic [7:0] status_q, error_q, secNum_q, cyl_q;
  logic [15:0] count_q;
  logic takeCmd, isStatus, isLockOff, wordTake, clearReq, pwMatch;
  logic queryAbort, clearOk;
  logic [7:0] queryReason;
  logic [15:0] progShown;

  // status value for a finished command; abort raises the error bit
  function automatic logic [7:0] finish_status(input logic abort);
    logic [7:0] s;
    s = 8'h00;
    s[ST_READY] = 1'b1;
    s[ST_SEEK_DONE] = 1'b1;
    s[ST_ERR] = abort;
    return s;
  endfunction

  function automatic logic [7:0] finish_error(input logic abort);
    logic [7:0] e;
    e = 8'h00;
    e[ERR_ABORT] = abort;
    return e;
  endfunction

  assign takeCmd = link.cmdStrobe && dev_q == DEV_IDLE;
  assign isStatus = link.cmdCode == CMD_SANITIZE;
  assign isLockOff = link.cmdCode == CMD_LOCK_OFF;
  assign wordTake = link.wordValid && drq_q;
  assign clearReq = link.countIn[CNT_CLEAR_FAILED];

  // status query is answered in any sanitize state, frozen and failed included
  always_comb begin
    queryAbort = 1'b0;
    queryReason = REASON_NONE;
    clearOk = 1'b0;
    if (link.feature != FEAT_STATUS) begin
      queryAbort = 1'b1;
      queryReason = REASON_BAD_FEATURE;
    end else if (clearReq && san_q == SANITIZE_FAILED_STATE && persist_q) begin
      clearOk = 1'b1;
    end else if (clearReq && san_q == SANITIZE_FAILED_STATE) begin
      queryAbort = 1'b1;
    end else if (unsanitized_q && (san_q == SANITIZE_FAILED_STATE || san_q == SANITIZE_SUCCEEDED_STATE)) begin
      queryAbort = 1'b1;
      queryReason = REASON_UNSANITIZED;
    end
  end

  // progress fraction over 65536, all ones outside an active operation
  assign progShown = (san_q == SANITIZE_ACTIVE_STATE) ? progress : PROGRESS_NONE;

  // sanitize state machine
  always_ff @(posedge clock) begin
    if (!resetn) begin
      san_q <= SANITIZE_IDLE_STATE;
    end else if (takeCmd && isStatus && clearOk) begin
      san_q <= SANITIZE_IDLE_STATE;
    end else begin
      case (san_q)
        SANITIZE_ACTIVE_STATE: begin
          if (opFailed) begin
            san_q <= SANITIZE_FAILED_STATE;
          end else if (opSucceeded) begin
            san_q <= SANITIZE_SUCCEEDED_STATE;
          end
        end
        SANITIZE_FROZEN_STATE: begin
          san_q <= SANITIZE_FROZEN_STATE;
        end
        default: begin
          if (freezeLock) begin
            san_q <= SANITIZE_FROZEN_STATE;
          end else if (opStart) begin
            san_q <= SANITIZE_ACTIVE_STATE;
          end
        end
      endcase
    end
  end

  // persist and unsanitized flags of the last operation
  always_ff @(posedge clock) begin
    if (!resetn) begin
      persist_q <= 1'b0;
      unsanitized_q <= 1'b0;
    end else if (opStart && san_q != SANITIZE_ACTIVE_STATE && san_q != SANITIZE_FROZEN_STATE && !freezeLock) begin
      persist_q <= opPersist;
      unsanitized_q <= 1'b0;
    end else if (san_q == SANITIZE_ACTIVE_STATE && (opFailed || opSucceeded)) begin
      unsanitized_q <= opUnsanitized;
    end
  end

  // completed-without-error flag, cleared by the retention reset or when a new operation starts
  always_ff @(posedge clock) begin
    if (!retainResetn) begin
      doneOk_q <= 1'b0;
    end else if (san_q == SANITIZE_ACTIVE_STATE && opSucceeded && !opFailed) begin
      doneOk_q <= 1'b1;
    end else if (san_q != SANITIZE_ACTIVE_STATE && san_q != SANITIZE_FROZEN_STATE && opStart && !freezeLock) begin
      doneOk_q <= 1'b0;
    end
  end

  // lock state; only the user password set can turn it back on
  always_ff @(posedge clock) begin
    if (!resetn) begin
      secOn_q <= 1'b0;
    end else if (dev_q == DEV_CHECK && !(!secOn_q && !idMaster_q) && pwMatch) begin
      secOn_q <= 1'b0;
    end else if (setUserPassword) begin
      secOn_q <= 1'b1;
    end
  end

  ssld_pw_check ssld_pw_check_i (
    .clock(clock),
    .resetn(resetn),
    .start(takeCmd),
    .wordTake(wordTake),
    .wordIndex(wordCnt_q),
    .wordData(link.wordData),
    .useMaster(idMaster_q),
    .userPassword(userPassword),
    .masterPassword(masterPassword),
    .matched(pwMatch)
  );

  // command sequencing and answer registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dev_q <= DEV_IDLE;
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      done_q <= 1'b0;
      lockOff_q <= 1'b0;
      wordCnt_q <= 8'h00;
      idMaster_q <= 1'b0;
      status_q <= finish_status(1'b0);
      error_q <= 8'h00;
      count_q <= 16'h0000;
      secNum_q <= 8'h00;
      cyl_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      lockOff_q <= 1'b0;
      case (dev_q)
        DEV_IDLE: begin
          if (takeCmd && isStatus) begin
            done_q <= 1'b1;
            status_q <= finish_status(queryAbort);
            error_q <= finish_error(queryAbort);
            count_q <= 16'h0000;
            count_q[CNT_DONE_OK] <= doneOk_q;
            count_q[CNT_IN_PROGRESS] <= san_q == SANITIZE_ACTIVE_STATE;
            count_q[CNT_FROZEN] <= san_q == SANITIZE_FROZEN_STATE;
            cyl_q <= progShown[15:8];
            secNum_q <= queryAbort ? queryReason : progShown[7:0];
          end else if (takeCmd && isLockOff) begin
            dev_q <= DEV_RECEIVE;
            busy_q <= 1'b1;
            drq_q <= 1'b1;
            wordCnt_q <= WORD_CONTROL;
            status_q <= 8'h00;
            status_q[ST_DRQ] <= 1'b1;
          end else if (takeCmd) begin
            done_q <= 1'b1;
            status_q <= finish_status(1'b1);
            error_q <= finish_error(1'b1);
            secNum_q <= REASON_NONE;
          end
        end
        DEV_RECEIVE: begin
          if (wordTake) begin
            if (wordCnt_q == WORD_CONTROL) begin
              idMaster_q <= link.wordData[ID_BIT];
            end
            wordCnt_q <= wordCnt_q + 8'h01;
            if (wordCnt_q == WORD_LAST) begin
              dev_q <= DEV_CHECK;
              drq_q <= 1'b0;
              status_q <= 8'h00;
              status_q[ST_BUSY] <= 1'b1;
            end
          end
        end
        DEV_CHECK: begin
          dev_q <= DEV_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          if ((!secOn_q && !idMaster_q) || !pwMatch) begin
            status_q <= finish_status(1'b1);
            error_q <= finish_error(1'b1);
          end else begin
            lockOff_q <= 1'b1;
            status_q <= finish_status(1'b0);
            error_q <= finish_error(1'b0);
          end
        end
        default: begin
          dev_q <= DEV_IDLE;
          busy_q <= 1'b0;
          drq_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.busy = busy_q;
  assign link.drq = drq_q;
  assign link.done = done_q;
  assign link.statusReg = status_q;
  assign link.errorReg = error_q;
  assign link.countOut = count_q;
  assign link.sectorNum = secNum_q;
  assign link.cylLow = cyl_q;
  assign sanitizeState = san_q;
  assign securityEnabled = secOn_q;
  assign lockDisabled = lockOff_q;
endmodule // ssld_device
`default_nettype wire

/* File: rtl/ssld_host.sv */
// host controller: APB registers drive commands over the link
`timescale 1ns/10ps
`default_nettype none
module ssld_host
  import ssld_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to device
  ssld_link_if.host_end link
);
  typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_SEND, HOST_WAIT} ssld_host_t;

  ssld_host_t st_q;
  logic [7:0] code_q;
  logic [15:0] feat_q, count_q;
  logic id_q;
  logic [31:0] pw_q [PW_REGS];
  logic doneFlag_q;
  logic [7:0] errRes_q, stRes_q, secRes_q, cylRes_q;
  logic [15:0] cntRes_q;
  logic strobe_q, wordValid_q;
  logic [15:0] wordData_q;
  logic [7:0] sent_q;
  logic [31:0] rdata_q;
  logic slverr_q;
  logic setup, wrAccess, cmdWrite, mapped, isPw;
  logic [2:0] pwIdx;
  logic [7:0] nextIdx;

  // password registers are a decoded window used for both reads and writes
  function automatic logic in_pw(input logic [7:0] a);
    return a >= REG_PW_BASE && a <= REG_PW_END;
  endfunction

  // word k of the sector: control word, then password, then zeros
  function automatic logic [15:0] sector_word(input logic [7:0] k, input logic id,
                                              input logic [31:0] lo, input logic [31:0] hi);
    logic [15:0] w;
    w = 16'h0000;
    if (k == WORD_CONTROL) begin
      w[ID_BIT] = id;
    end else if (k >= WORD_PW_FIRST && k <= WORD_PW_LAST) begin
      w = k[0] ? lo[15:0] : lo[31:16];
    end
    return w;
  endfunction

  assign setup = psel && !penable;
  assign wrAccess = psel && penable && pwrite;
  assign isPw = in_pw(paddr);
  assign pwIdx = 3'((paddr - REG_PW_BASE) >> 2);
  assign mapped = isPw || paddr == REG_COMMAND || paddr == REG_COUNT || paddr == REG_STATUS
                  || paddr == REG_RESULT;
  assign cmdWrite = wrAccess && paddr == REG_COMMAND && st_q == HOST_IDLE;
  assign nextIdx = sent_q + 8'h01;

  // read data and error are prepared in the setup cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= !mapped || (pwrite && (paddr == REG_RESULT || (paddr == REG_COMMAND && st_q != HOST_IDLE)));
      rdata_q <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          REG_COMMAND: rdata_q <= {feat_q, 8'h00, code_q};
          REG_COUNT: rdata_q <= {15'h0000, id_q, count_q};
          REG_STATUS: rdata_q <= {8'h00, stRes_q, errRes_q, 6'h00, doneFlag_q, st_q != HOST_IDLE};
          REG_RESULT: rdata_q <= {cylRes_q, secRes_q, cntRes_q};
          default: rdata_q <= isPw ? pw_q[pwIdx] : 32'h0000_0000;
        endcase
      end
    end
  end

  // software-written registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      code_q <= 8'h00;
      feat_q <= 16'h0000;
      count_q <= 16'h0000;
      id_q <= 1'b0;
      for (int i = 0; i < PW_REGS; i++) begin
        pw_q[i] <= 32'h0000_0000;
      end
    end else if (cmdWrite) begin
      code_q <= pwdata[7:0];
      feat_q <= pwdata[31:16];
    end else if (wrAccess && paddr == REG_COUNT) begin
      count_q <= pwdata[15:0];
      id_q <= pwdata[16];
    end else if (wrAccess && isPw) begin
      pw_q[pwIdx] <= pwdata;
    end
  end

  // command sequence on the link
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q <= HOST_IDLE;
      strobe_q <= 1'b0;
      wordValid_q <= 1'b0;
      wordData_q <= 16'h0000;
      sent_q <= 8'h00;
    end else begin
      strobe_q <= 1'b0;
      case (st_q)
        HOST_IDLE: begin
          if (cmdWrite) begin
            st_q <= HOST_ISSUE;
          end
        end
        HOST_ISSUE: begin
          if (!link.busy) begin
            strobe_q <= 1'b1;
            sent_q <= WORD_CONTROL;
            wordData_q <= sector_word(WORD_CONTROL, id_q, pw_q[0], pw_q[0]);
            st_q <= (code_q == CMD_LOCK_OFF) ? HOST_SEND : HOST_WAIT;
          end
        end
        HOST_SEND: begin
          wordValid_q <= 1'b1;
          if (wordValid_q && link.drq) begin
            sent_q <= nextIdx;
            wordData_q <= sector_word(nextIdx, id_q, pw_q[3'((nextIdx - WORD_PW_FIRST) >> 1)], 32'h0000_0000);
            if (sent_q == WORD_LAST) begin
              wordValid_q <= 1'b0;
              st_q <= HOST_WAIT;
            end
          end
        end
        HOST_WAIT: begin
          if (link.done) begin
            st_q <= HOST_IDLE;
          end
        end
        default: st_q <= HOST_IDLE;
      endcase
    end
  end

  // answer capture; a new completion wins over a software clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      doneFlag_q <= 1'b0;
      errRes_q <= 8'h00;
      stRes_q <= 8'h00;
      secRes_q <= 8'h00;
      cylRes_q <= 8'h00;
      cntRes_q <= 16'h0000;
    end else if (link.done && st_q == HOST_WAIT) begin
      doneFlag_q <= 1'b1;
      errRes_q <= link.errorReg;
      stRes_q <= link.statusReg;
      secRes_q <= link.sectorNum;
      cylRes_q <= link.cylLow;
      cntRes_q <= link.countOut;
    end else if (wrAccess && paddr == REG_STATUS && pwdata[HST_DONE]) begin
      doneFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  assign prdata = rdata_q;
  assign pslverr = slverr_q;
  assign link.cmdStrobe = strobe_q;
  assign link.cmdCode = code_q;
  assign link.feature = feat_q;
  assign link.countIn = count_q;
  assign link.wordValid = wordValid_q;
  assign link.wordData = wordData_q;
endmodule // ssld_host
`default_nettype wire

/* File: tb/ssld_link_checker.sv */
// link protocol checker for the host and device ends
`timescale 1ns/10ps
`default_nettype none
module ssld_link_checker
  import ssld_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // host to device
  input wire logic cmdStrobe,
  input wire logic [7:0] cmdCode,
  input wire logic wordValid,
  // device to host
  input wire logic busy,
  input wire logic drq,
  input wire logic done,
  input wire logic [7:0] statusReg,
  input wire logic [7:0] errorReg,
  input wire logic [15:0] countOut,
  input wire logic [7:0] sectorNum,
  input wire logic [7:0] cylLow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence takeCmd(logic [7:0] c);
    cmdStrobe && !busy && !drq && cmdCode == c;
  endsequence
  sequence lastWord;
    drq && wordValid ##1 !drq;
  endsequence
  a_done_one_cycle: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_status_answer: assert property (takeCmd(CMD_SANITIZE) |=> done)
    else $error("status query not answered next cycle");
  a_lock_start: assert property (takeCmd(CMD_LOCK_OFF) |=> drq && busy && !done)
    else $error("lock disable did not request the sector");
  a_lock_finish: assert property (lastWord |=> done && !busy)
    else $error("lock disable did not complete after the sector");
  a_words_no_done: assert property (drq |-> !done)
    else $error("completion while still taking words");
  a_abort_flags: assert property (done && errorReg[ERR_ABORT] |-> statusReg[ST_ERR] && !statusReg[ST_BUSY])
    else $error("abort without error status or with busy");
  a_ok_flags: assert property (done && !errorReg[ERR_ABORT] |-> !statusReg[ST_ERR] && !statusReg[ST_BUSY])
    else $error("error status without abort");
  a_progress_ones: assert property (done && $past(cmdStrobe) && $past(cmdCode) == CMD_SANITIZE && !countOut[CNT_IN_PROGRESS]
    && !errorReg[ERR_ABORT] |-> {cylLow, sectorNum} == PROGRESS_NONE)
    else $error("progress not all ones while idle");
  a_frozen_idle: assert property (done && countOut[CNT_FROZEN] |-> !countOut[CNT_IN_PROGRESS])
    else $error("frozen and in progress together");
endmodule // ssld_link_checker
`default_nettype wire

/* File: tb/sanitize_status_and_lock_disable_tb.sv */
// testbench joining host and device ends over the link
`timescale 1ns/10ps
`default_nettype none
module sanitize_status_and_lock_disable_tb
  import ssld_pkg::*;
;
  logic clock = 0, resetn = 0, retainResetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, pe;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, st;
  logic opStart = 0, opPersist = 0, opFailed = 0, opSucceeded = 0, opUnsanitized = 0;
  logic freezeLock = 0, setUserPassword = 0, securityEnabled, lockDisabled;
  logic [15:0] progress = 16'h0000;
  logic [PW_BITS-1:0] userPw, masterPw;
  ssld_sanitize_t sanitizeState;
  int errors = 0, compares = 0, unlocks = 0;
  always #5 clock = ~clock;
  always @(posedge clock) if (lockDisabled === 1'b1) unlocks++;
  ssld_link_if link ();
  ssld_host ssld_host_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  ssld_device ssld_device_i (.clock(clock), .resetn(resetn), .retainResetn(retainResetn), .link(link),
    .opStart(opStart), .opPersist(opPersist), .opFailed(opFailed), .opSucceeded(opSucceeded),
    .opUnsanitized(opUnsanitized), .freezeLock(freezeLock), .progress(progress), .userPassword(userPw),
    .masterPassword(masterPw), .setUserPassword(setUserPassword), .sanitizeState(sanitizeState),
    .securityEnabled(securityEnabled), .lockDisabled(lockDisabled));
  ssld_link_checker ssld_link_checker_i (.clock(clock), .resetn(resetn), .cmdStrobe(link.cmdStrobe),
    .cmdCode(link.cmdCode), .wordValid(link.wordValid), .busy(link.busy), .drq(link.drq), .done(link.done),
    .statusReg(link.statusReg), .errorReg(link.errorReg), .countOut(link.countOut),
    .sectorNum(link.sectorNum), .cylLow(link.cylLow));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    pe = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  // issue one command, wait for sticky done, fetch the answer
  task automatic run(input logic [7:0] c, input logic [15:0] f, input logic [16:0] n);
    int k;
    apb(1, REG_COUNT, {15'h0, n});
    apb(1, REG_COMMAND, {f, 8'h00, c});
    k = 0;
    r = 0;
    while (r[HST_DONE] !== 1'b1 && k < 400) begin
      apb(0, REG_STATUS, 0);
      k++;
    end
    if (r[HST_DONE] !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: no completion", $time);
    end
    st = r;
    apb(1, REG_STATUS, 32'h2);
    apb(0, REG_RESULT, 0);
  endtask
  task automatic want(input logic ab);
    chk({st[23], st[16], st[10]}, {1'b0, ab, ab});
  endtask
  task automatic ev(input int w);
    case (w)
      0: opStart <= 1;
      1: opFailed <= 1;
      2: opSucceeded <= 1;
      3: freezeLock <= 1;
      default: setUserPassword <= 1;
    endcase
    @(posedge clock);
    {opStart, opFailed, opSucceeded, freezeLock, setUserPassword} <= 5'h00;
    @(posedge clock);
  endtask
  task automatic do_reset;
    resetn <= 0;
    repeat (20) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
  endtask
  task automatic t_idle;
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    want(0);
    chk(r[15:13], 3'b000);
    chk({r[31:24], r[23:16]}, PROGRESS_NONE);
    run(8'h00, 0, 0);
    want(1);
    chk(pe, 1'b0);
    apb(1, REG_RESULT, 32'h0);
    chk(pe, 1'b1);
    $display("test idle done");
  endtask
  task automatic t_active;
    opPersist <= 1;
    progress <= 16'h1234;
    ev(0);
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    chk(r[15:13], 3'b010);
    chk({r[31:24], r[23:16]}, 16'h1234);
    ev(1);
    run(CMD_SANITIZE, FEAT_STATUS, 1);
    want(0);
    chk(32'(sanitizeState), 32'(SANITIZE_IDLE_STATE));
    $display("test active done");
  endtask
  task automatic t_done;
    ev(0);
    ev(2);
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    chk(r[15:13], 3'b100);
    do_reset;
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    chk(r[15:13], 3'b100);
    ev(0);
    opUnsanitized <= 1;
    ev(2);
    opUnsanitized <= 0;
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    want(1);
    chk(r[23:16], REASON_UNSANITIZED);
    $display("test done flag done");
  endtask
  task automatic t_fail;
    opPersist <= 0;
    ev(0);
    ev(1);
    run(CMD_SANITIZE, FEAT_STATUS, 1);
    want(1);
    chk(r[23:16], REASON_NONE);
    chk(32'(sanitizeState), 32'(SANITIZE_FAILED_STATE));
    $display("test fail done");
  endtask
  task automatic t_frozen;
    do_reset;
    ev(3);
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    want(0);
    chk(r[15:13], 3'b001);
    run(CMD_SANITIZE, 16'h0001, 0);
    want(1);
    chk(r[23:16], REASON_BAD_FEATURE);
    do_reset;
    run(CMD_SANITIZE, FEAT_STATUS, 0);
    chk(r[15:13], 3'b000);
    $display("test frozen done");
  endtask
  task automatic t_lock;
    int k;
    for (int i = 0; i < PW_REGS; i++) apb(1, REG_PW_BASE + 8'(4 * i), userPw[i*32+:32]);
    run(CMD_LOCK_OFF, 0, 17'h00000);
    want(1);
    ev(4);
    chk(securityEnabled, 1'b1);
    k = unlocks;
    run(CMD_LOCK_OFF, 0, 17'h00000);
    want(0);
    chk(unlocks - k, 1);
    chk(securityEnabled, 1'b0);
    run(CMD_LOCK_OFF, 0, 17'h10000);
    want(1);
    for (int i = 0; i < PW_REGS; i++) apb(1, REG_PW_BASE + 8'(4 * i), masterPw[i*32+:32]);
    run(CMD_LOCK_OFF, 0, 17'h10000);
    want(0);
    $display("test lock done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    $display("mismatch at %0t: timeout", $time);
    finish_test;
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      userPw[i*32+:32] <= 32'h1111_0000 + i;
      masterPw[i*32+:32] <= 32'h2222_0000 + i;
    end
    do_reset;
    retainResetn <= 1;
    t_idle;
    t_active;
    t_done;
    t_fail;
    t_frozen;
    t_lock;
    finish_test;
  end
endmodule // sanitize_status_and_lock_disable_tb
`default_nettype wire
